// file: mtp_pkg.sv
package mtp_pkg;
  // Register byte offsets
  localparam logic [7:0] MOTOR_CFG_OFS  = 8'h00;
  localparam logic [7:0] PROT_MODE_OFS  = 8'h04;
  localparam logic [7:0] OVL_TIME_OFS   = 8'h08;
  localparam logic [7:0] SENS_THR_OFS   = 8'h0c;
  localparam logic [7:0] LO_LVL_OFS     = 8'h10;
  localparam logic [7:0] LO_TIME_OFS    = 8'h14;
  localparam logic [7:0] HI_LVL_OFS     = 8'h18;
  localparam logic [7:0] HI_TIME_OFS    = 8'h1c;
  localparam logic [7:0] TUNE_STAT_OFS  = 8'h20;
  localparam logic [7:0] FAULT_OFS      = 8'h24;
  localparam logic [7:0] LEARN_BASE_OFS = 8'h40;
  // Learned table: 0..4 equivalent circuit, 5 kind, 6 ppr, 7 division, 8 angle
  localparam int        LEARN_N   = 9;
  localparam int        EQ_N      = 5;
  localparam logic [3:0] IDX_PPR  = 4'd6;
  localparam logic [3:0] IDX_DIV  = 4'd7;
  localparam logic [3:0] IDX_ANG  = 4'd8;
  localparam logic [15:0] PPR_RST = 16'd1024;
  localparam logic [15:0] DIV_RST = 16'd1;
  // Field positions
  localparam int MT_BIT = 0;
  localparam int POL_BIT = 4;
  localparam int EXP_LSB = 8;
  localparam int TENS_BIT = 4;
  // Reset values (0.1 s, 0.01 units)
  localparam logic        POL_RST   = 1'b1;
  localparam logic [3:0]  EXP_RST   = 4'd11;
  localparam logic [3:0]  EXP_MAX   = 4'd11;
  localparam logic [15:0] OVL_RST   = 16'd600;
  localparam logic [15:0] THR_RST   = 16'd500;
  localparam logic [15:0] LO_LVL_RST = 16'd15000;
  localparam logic [15:0] LO_TIM_RST = 16'd600;
  localparam logic [15:0] HI_LVL_RST = 16'd12000;
  localparam logic [15:0] HI_TIM_RST = 16'd300;
  // Protection modes and tuning codes
  localparam logic [1:0] PM_CURRENT = 2'd0;
  localparam logic [1:0] PM_SENSOR  = 2'd1;
  localparam logic [1:0] PM_NONE    = 2'd2;
  localparam logic [3:0] CODE_MAX   = 4'd7;
  localparam logic [3:0] COUNT_TOP  = 4'd9;
  localparam logic [15:0] RATED_PCT = 16'd10000;
  localparam logic [15:0] OVL_SCALE = 16'd5000;
  localparam logic [15:0] LOW_SPEED_FREQ = 16'd1000;
  // Protection time base
  localparam int CLK_NS  = 10;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  typedef enum logic {TS_IDLE, TS_RUN} mtp_tune_e;
endpackage : mtp_pkg

// file: mtp_top.sv
// How it works
// - Selector codes 0 normal, 1-7 methods
// - Selector returns to zero after tuning
// - Selector read-only; only panel confirm starts
// - Countdown 9 to 0, failure flagged
// - Successful results stored until overwritten
// - Equivalent parameters only for asynchronous motor
// - Encoder learned fields not operator settable
// - Synchronous phase angle captured on first run
// - Polarity setting inverts sensed direction
// - Interpolation factor is two to N
// - Units digit picks current, sensor, none
// - Tens digit clear enables low-speed derating
// - Accumulated overload reaching limit faults
// - Accumulator runs always, cleared at power-up
// - Sensor above threshold faults immediately
// - No-action mode gives no overload protection
// - Separate low/high overcurrent level-time pairs
// - Motor type 0 asynchronous, 1 synchronous
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mtp_top #(
  parameter int TICK_CYC = mtp_pkg::TICK_CYC
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  input  wire logic [3:0]  PANEL_CODE_I,
  input  wire logic        PANEL_CONFIRM_I,
  input  wire logic        TUNE_STEP_I,
  input  wire logic        TUNE_FAIL_I,
  input  wire logic        LEARN_WE_I,
  input  wire logic [3:0]  LEARN_SEL_I,
  input  wire logic [15:0] LEARN_DATA_I,
  output logic             TUNE_START_O,
  output logic      [2:0]  TUNE_METHOD_O,
  input  wire logic        RUN_I,
  input  wire logic [15:0] ENC_ANGLE_I,
  input  wire logic        ENC_A_I,
  input  wire logic        ENC_B_I,
  output logic             ENC_DIR_O,
  output logic      [11:0] ENC_INTERP_O,
  input  wire logic [15:0] CURRENT_I,
  input  wire logic [15:0] FREQ_I,
  input  wire logic [15:0] THERM_I,
  output logic             OVERLOAD_FAULT_O,
  output logic             OVERHEAT_FAULT_O,
  output logic             OC_LOW_FAULT_O,
  output logic             OC_HIGH_FAULT_O
);
  import mtp_pkg::*;

  logic            mtype_q, pol_q, tens_q;
  logic [3:0]      exp_q;
  logic [1:0]      units_q;
  logic [15:0]     ovl_q, thr_q;
  logic [15:0]     lvl_q [2];
  logic [15:0]     tim_q [2];
  logic [15:0]     lrn_q [LEARN_N];
  logic [15:0]     shd_q [LEARN_N];
  mtp_tune_e       st_q;
  logic [2:0]      meth_q;
  logic [3:0]      cnt_q;
  logic            done_q, fail_q, ok_q, ang_got_q;
  logic [3:0]      flt_q;
  logic [3:0]      code_s1_q, code_s2_q;
  logic [2:0]      conf_q;
  logic [2:0]      a_q, b_q;
  logic            dir_raw_q;
  logic [31:0]     tick_q;
  logic            tick;
  logic [31:0]     acc_q;
  logic [15:0]     occ_q [2];
  logic [1:0]      oc_hit;
  logic            confirm, start, wr_cfg, low_spd;
  logic [3:0]      lidx;
  logic            lrn_hit;

  assign wr_cfg  = WR_I;
  assign low_spd = FREQ_I < LOW_SPEED_FREQ;
  assign lidx    = 4'((ADDR_I - LEARN_BASE_OFS) >> 2);
  // Learned window decode; bounded so addresses above the table never alias
  assign lrn_hit = ADDR_I >= LEARN_BASE_OFS && ADDR_I < LEARN_BASE_OFS + 8'(4 * LEARN_N)
                   && ADDR_I[1:0] == 2'b00;

  // Settings written by software
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      mtype_q <= 1'b0;
      pol_q   <= POL_RST;
      exp_q   <= EXP_RST;
      units_q <= PM_CURRENT;
      tens_q  <= 1'b0;
      ovl_q   <= OVL_RST;
      thr_q   <= THR_RST;
      lvl_q[0] <= LO_LVL_RST;
      tim_q[0] <= LO_TIM_RST;
      lvl_q[1] <= HI_LVL_RST;
      tim_q[1] <= HI_TIM_RST;
    end else if (wr_cfg) begin
      case (ADDR_I)
        MOTOR_CFG_OFS: begin
          mtype_q <= WDATA_I[MT_BIT];
          pol_q   <= WDATA_I[POL_BIT];
          if (WDATA_I[EXP_LSB+:4] <= EXP_MAX) exp_q <= WDATA_I[EXP_LSB+:4];
        end
        PROT_MODE_OFS: begin
          if (WDATA_I[1:0] <= PM_NONE) units_q <= WDATA_I[1:0];
          tens_q <= WDATA_I[TENS_BIT];
        end
        OVL_TIME_OFS: ovl_q <= WDATA_I[15:0];
        SENS_THR_OFS: thr_q <= WDATA_I[15:0];
        LO_LVL_OFS:   lvl_q[0] <= WDATA_I[15:0];
        LO_TIME_OFS:  tim_q[0] <= WDATA_I[15:0];
        HI_LVL_OFS:   lvl_q[1] <= WDATA_I[15:0];
        HI_TIME_OFS:  tim_q[1] <= WDATA_I[15:0];
        default: ;
      endcase
    end
  end

  // Panel inputs synchronised, confirm edge from second stage on
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      code_s1_q <= 4'h0;
      code_s2_q <= 4'h0;
      conf_q    <= 3'h0;
    end else begin
      code_s1_q <= PANEL_CODE_I;
      code_s2_q <= code_s1_q;
      conf_q    <= {conf_q[1:0], PANEL_CONFIRM_I};
    end
  end
  assign confirm = conf_q[1] & ~conf_q[2];
  // zero and codes above seven refused
  assign start   = (st_q == TS_IDLE) && confirm && code_s2_q != 4'h0 && code_s2_q <= CODE_MAX;

  // Tuning sequencer
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_q   <= TS_IDLE;
      meth_q <= 3'h0;
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      ok_q   <= 1'b0;
    end else begin
      ok_q <= 1'b0;
      case (st_q)
        TS_IDLE: begin
          if (start) begin
            st_q   <= TS_RUN;
            meth_q <= code_s2_q[2:0];
            cnt_q  <= COUNT_TOP;
            done_q <= 1'b0;
            fail_q <= 1'b0;
          end
        end
        TS_RUN: begin
          if (TUNE_FAIL_I) begin
            fail_q <= 1'b1;
            meth_q <= 3'h0;
            st_q   <= TS_IDLE;
          end else if (TUNE_STEP_I) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
              meth_q <= 3'h0;
              done_q <= 1'b1;
              ok_q   <= 1'b1;
              st_q   <= TS_IDLE;
            end
          end
        end
        default: st_q <= TS_IDLE;
      endcase
    end
  end
  assign TUNE_START_O  = start;
  assign TUNE_METHOD_O = meth_q;

  // Learned values: shadow during run, committed on success
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < LEARN_N; i++) begin
        lrn_q[i] <= 16'h0;
        shd_q[i] <= 16'h0;
      end
      lrn_q[IDX_PPR] <= PPR_RST;
      lrn_q[IDX_DIV] <= DIV_RST;
      ang_got_q <= 1'b0;
    end else begin
      if (st_q == TS_RUN && LEARN_WE_I && LEARN_SEL_I < 4'(LEARN_N))
        shd_q[LEARN_SEL_I] <= LEARN_DATA_I;
      if (ok_q) begin
        for (int i = 0; i < LEARN_N; i++) begin
          if (i >= EQ_N || !mtype_q) lrn_q[i] <= shd_q[i];
        end
      // angle caught on first synchronous run
      end else if (mtype_q && RUN_I && !ang_got_q) begin
        lrn_q[IDX_ANG] <= ENC_ANGLE_I;
        ang_got_q      <= 1'b1;
      // manual entry reaches equivalent circuit only
      end else if (WR_I && lrn_hit && lidx < 4'(EQ_N))
        lrn_q[lidx] <= WDATA_I[15:0];
    end
  end

  // Encoder direction from synchronised quadrature
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      a_q <= 3'h0;
      b_q <= 3'h0;
      dir_raw_q <= 1'b0;
      ENC_DIR_O <= 1'b0;
      ENC_INTERP_O <= 12'h0;
    end else begin
      a_q <= {a_q[1:0], ENC_A_I};
      b_q <= {b_q[1:0], ENC_B_I};
      if (a_q[1] & ~a_q[2]) dir_raw_q <= ~b_q[1];
      ENC_DIR_O <= pol_q ? dir_raw_q : ~dir_raw_q;
      ENC_INTERP_O <= 12'(12'h1 << exp_q);
    end
  end

  // Protection time base
  always_ff @(posedge MCLK_I) begin
    if (RST_I || tick) tick_q <= 32'h0;
    else tick_q <= tick_q + 32'h1;
  end
  assign tick = tick_q == 32'(TICK_CYC - 1);

  // runs stopped or running, only reset clears
  always_ff @(posedge MCLK_I) begin
    if (RST_I) acc_q <= 32'h0;
    else if (tick) begin
      if (CURRENT_I > RATED_PCT) begin
        if (!tens_q && low_spd)
          acc_q <= acc_q + {15'h0, CURRENT_I - RATED_PCT, 1'b0};
        else
          acc_q <= acc_q + {16'h0, CURRENT_I - RATED_PCT};
      end else if (acc_q != 32'h0)
        acc_q <= acc_q - 32'h1;
    end
  end

  for (genvar b = 0; b < 2; b++) begin : g_band
    logic in_band;
    assign in_band   = (b == 0) ? low_spd : !low_spd;
    assign oc_hit[b] = occ_q[b] > tim_q[b];
    always_ff @(posedge MCLK_I) begin
      if (RST_I || !(in_band && CURRENT_I > lvl_q[b])) occ_q[b] <= 16'h0;
      else if (tick && !oc_hit[b]) occ_q[b] <= occ_q[b] + 16'h1;
    end
  end

  // Sticky faults, write one to clear, set wins
  always_ff @(posedge MCLK_I) begin
    if (RST_I) flt_q <= 4'h0;
    else begin
      for (int i = 0; i < 4; i++)
        if (WR_I && ADDR_I == FAULT_OFS && WDATA_I[i]) flt_q[i] <= 1'b0;
      if (units_q == PM_CURRENT && acc_q >= 32'(ovl_q) * 32'(OVL_SCALE)) flt_q[0] <= 1'b1;
      if (units_q == PM_SENSOR && THERM_I > thr_q) flt_q[1] <= 1'b1;
      if (oc_hit[0]) flt_q[2] <= 1'b1;
      if (oc_hit[1]) flt_q[3] <= 1'b1;
    end
  end
  assign OVERLOAD_FAULT_O = flt_q[0];
  assign OVERHEAT_FAULT_O = flt_q[1];
  assign OC_LOW_FAULT_O   = flt_q[2];
  assign OC_HIGH_FAULT_O  = flt_q[3];

  // Read data one cycle after the strobe
  always_ff @(posedge MCLK_I) begin
    if (RST_I || !RD_I) RDATA_O <= 32'h0;
    else begin
      case (ADDR_I)
        MOTOR_CFG_OFS: RDATA_O <= {20'h0, exp_q, 3'h0, pol_q, 3'h0, mtype_q};
        PROT_MODE_OFS: RDATA_O <= {27'h0, tens_q, 2'h0, units_q};
        OVL_TIME_OFS:  RDATA_O <= {16'h0, ovl_q};
        SENS_THR_OFS:  RDATA_O <= {16'h0, thr_q};
        LO_LVL_OFS:    RDATA_O <= {16'h0, lvl_q[0]};
        LO_TIME_OFS:   RDATA_O <= {16'h0, tim_q[0]};
        HI_LVL_OFS:    RDATA_O <= {16'h0, lvl_q[1]};
        HI_TIME_OFS:   RDATA_O <= {16'h0, tim_q[1]};
        TUNE_STAT_OFS: RDATA_O <= {21'h0, st_q == TS_RUN, fail_q, done_q, cnt_q, 1'b0, meth_q};
        FAULT_OFS:     RDATA_O <= {28'h0, flt_q};
        default: begin
          if (lrn_hit)
            RDATA_O <= {16'h0, lrn_q[lidx]};
          else RDATA_O <= 32'h0;
        end
      endcase
    end
  end

  property p_sel_zero;
    @(posedge MCLK_I) disable iff (RST_I)
    (st_q == TS_RUN && !TUNE_FAIL_I && TUNE_STEP_I && cnt_q == 4'h1)
      |=> meth_q == 3'h0 && done_q && cnt_q == 4'h0 ##1 lrn_q[IDX_DIV] == $past(shd_q[IDX_DIV]);
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("selector not cleared");
  property p_ro;
    @(posedge MCLK_I) disable iff (RST_I)
    (st_q == TS_IDLE && !confirm) |=> st_q == TS_IDLE && $stable(meth_q);
  endproperty
  a_ro: assert property (p_ro) else $error("tuning started without confirm");
  property p_count;
    @(posedge MCLK_I) disable iff (RST_I) start |=> cnt_q == 4'd9 && st_q == TS_RUN;
  endproperty
  a_count: assert property (p_count) else $error("countdown not nine");
  property p_fail;
    @(posedge MCLK_I) disable iff (RST_I) (st_q == TS_RUN && TUNE_FAIL_I) |=> fail_q && !done_q;
  endproperty
  a_fail: assert property (p_fail) else $error("failure not shown");
  property p_rej;
    @(posedge MCLK_I) disable iff (RST_I)
    (st_q == TS_IDLE && confirm && code_s2_q > 4'd7) |=> st_q == TS_IDLE;
  endproperty
  a_rej: assert property (p_rej) else $error("bad code accepted");
  property p_pol;
    @(posedge MCLK_I) disable iff (RST_I)
    ($changed(pol_q) && $stable(dir_raw_q)) |=> $changed(ENC_DIR_O);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not inverting");
  property p_interp;
    @(posedge MCLK_I) disable iff (RST_I) exp_q == 4'd7 ##1 exp_q == 4'd7 |-> ENC_INTERP_O == 12'd128;
  endproperty
  a_interp: assert property (p_interp) else $error("interpolation wrong");
  property p_heat;
    @(posedge MCLK_I) disable iff (RST_I) (units_q == 2'd1 && THERM_I > thr_q) |=> OVERHEAT_FAULT_O;
  endproperty
  a_heat: assert property (p_heat) else $error("overheat missed");
  property p_none;
    @(posedge MCLK_I) disable iff (RST_I)
    (units_q == 2'd2 && !OVERLOAD_FAULT_O && !OVERHEAT_FAULT_O) |=> !OVERLOAD_FAULT_O && !OVERHEAT_FAULT_O;
  endproperty
  a_none: assert property (p_none) else $error("protection in no-action mode");
  property p_oc;
    @(posedge MCLK_I) disable iff (RST_I) oc_hit[1] |=> OC_HIGH_FAULT_O;
  endproperty
  a_oc: assert property (p_oc) else $error("high band overcurrent missed");
  c_tune_ok:   cover property (@(posedge MCLK_I) disable iff (RST_I) ok_q);
  c_tune_fail: cover property (@(posedge MCLK_I) disable iff (RST_I) st_q == TS_RUN && TUNE_FAIL_I);
  c_overload:  cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(OVERLOAD_FAULT_O));
  c_oc_low:    cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(OC_LOW_FAULT_O));
endmodule : mtp_top

// file: mtp_motor_model.sv
`timescale 1ns/1ps
// Tuning engine and motor: learned values, then nine countdown steps
module mtp_motor_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        slow_i,
  input  wire logic        fail_req_i,
  input  wire logic [15:0] base_i,
  output logic             step_o,
  output logic             fail_o,
  output logic             lwe_o,
  output logic      [3:0]  lsel_o,
  output logic      [15:0] ldata_o
);
  logic       act_q;
  logic [5:0] cyc_q;
  logic [3:0] cnt_q;
  initial begin
    {step_o, fail_o, lwe_o, act_q} = 4'h0;
    lsel_o  = 4'h0;
    ldata_o = 16'h0;
  end
  // Learned words first, steps later; fast or slow spacing; fail on demand
  always @(posedge clk_i) begin
    step_o  <= 1'b0;
    fail_o  <= 1'b0;
    lwe_o   <= 1'b0;
    ldata_o <= ~ldata_o; // Released bus toggles, never holds
    if (rst_i) begin
      act_q <= 1'b0;
    end else if (start_i) begin
      act_q <= 1'b1;
      cyc_q <= 6'h0;
      cnt_q <= 4'h0;
    end else if (act_q) begin
      cyc_q <= cyc_q + 6'h1;
      if (cyc_q < 6'h9) begin
        lwe_o   <= 1'b1;
        lsel_o  <= cyc_q[3:0];
        ldata_o <= base_i + 16'(cyc_q);
      end else if (cyc_q >= 6'hc && (!slow_i || cyc_q[1:0] == 2'h0)) begin
        cnt_q <= cnt_q + 4'h1;
        if (fail_req_i && cnt_q == 4'h3) begin
          fail_o <= 1'b1;
          act_q  <= 1'b0;
        end else begin
          step_o <= 1'b1;
          if (cnt_q == 4'h8) act_q <= 1'b0;
        end
      end
    end
  end
endmodule : mtp_motor_model

// file: motor_tune_and_protect_test.sv
`timescale 1ns/1ps
module motor_tune_and_protect_test;
  import mtp_pkg::*;
  localparam int TK = 10;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, pconf = 0, run = 0, ea = 0, eb = 0;
  logic        slow = 0, freq_fail = 0, rd_seen = 0, step, fl, lwe, tstart, edir, d1;
  logic        f_ovl, f_oh, f_lo, f_hi;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0, rdata, mv;
  logic [3:0]  pcode = 0, lsel;
  logic [2:0]  tmeth;
  logic [11:0] interp;
  logic [15:0] ldata, angle = 0, cur = 0, freq = 0, therm = 0, lbase = 0, a0, keep;
  logic [63:0] exp_q[$];
  int          seed = 22127, fail_count = 0, cmp_count = 0, n;
  logic [7:0]  ra[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                          8'h20, 8'h24, 8'h5c, 8'hfc};
  logic [31:0] rv[12] = '{32'h0b10, 32'h0, 32'(OVL_RST), 32'(THR_RST), 32'(LO_LVL_RST),
                          32'(LO_TIM_RST), 32'(HI_LVL_RST), 32'(HI_TIM_RST), 32'h0,
                          32'h0, 32'(DIV_RST), 32'h0};
  always #5 clk = ~clk;
  mtp_top #(.TICK_CYC(TK)) u_mtp_top (.MCLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PANEL_CODE_I(pcode),
    .PANEL_CONFIRM_I(pconf), .TUNE_STEP_I(step), .TUNE_FAIL_I(fl), .LEARN_WE_I(lwe),
    .LEARN_SEL_I(lsel), .LEARN_DATA_I(ldata), .TUNE_START_O(tstart),
    .TUNE_METHOD_O(tmeth), .RUN_I(run), .ENC_ANGLE_I(angle), .ENC_A_I(ea), .ENC_B_I(eb),
    .ENC_DIR_O(edir), .ENC_INTERP_O(interp), .CURRENT_I(cur), .FREQ_I(freq),
    .THERM_I(therm), .OVERLOAD_FAULT_O(f_ovl), .OVERHEAT_FAULT_O(f_oh),
    .OC_LOW_FAULT_O(f_lo), .OC_HIGH_FAULT_O(f_hi));
  mtp_motor_model u_mtp_motor_model (.clk_i(clk), .rst_i(rst), .start_i(tstart),
    .slow_i(slow), .fail_req_i(freq_fail), .base_i(lbase), .step_o(step), .fail_o(fl),
    .lwe_o(lwe), .lsel_o(lsel), .ldata_o(ldata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    exp_q.push_back({m, e & m});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  // Count cycles until the chosen fault flag rises, at most 80
  task automatic wait_fault(input int which, output int cnt);
    cnt = 0;
    while (cnt < 80 && !((which == 0) ? f_ovl === 1'b1 : (which == 1) ? f_lo === 1'b1
           : f_hi === 1'b1)) begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_fault
  // Eight quadrature steps, A leading or B leading
  task automatic quad(input bit fwd);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {ea, eb} <= fwd ? {i[1] ^ i[0], i[1]} : {i[1], i[1] ^ i[0]};
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : quad
  // Panel confirm of one code; a run must follow only for codes 1 to 7
  task automatic run_tune(input logic [3:0] c, input bit bad);
    bit ok;
    ok = 0;
    @(posedge clk);
    pcode <= c;
    slow <= c[0];
    @(posedge clk);
    pconf <= 1'b1;
    for (int k = 0; k < 8 && !ok; k++) begin
      @(negedge clk);
      ok = (tstart === 1'b1);
    end
    @(posedge clk);
    pconf <= 1'b0;
    check(32'(ok), 32'(c >= 4'h1 && c <= CODE_MAX));
    if (ok) begin
      @(negedge clk);
      check(32'(tmeth), 32'(c));
      rd_reg(TUNE_STAT_OFS, 32'h490 | 32'(c));
      for (int k = 0; k < 100 && tmeth !== 3'h0; k++) @(negedge clk);
      repeat (3) @(posedge clk);
      rd_reg(TUNE_STAT_OFS, bad ? 32'h200 : 32'h100, bad ? 32'h607 : '1);
    end
  endtask : run_tune
  // Read data stand in the cycle after the strobe: compare with the oldest note
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      check(rdata & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    rd_seen <= rd;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 12; i++) rd_reg(ra[i], rv[i]);
    rd_reg(LEARN_BASE_OFS + 8'h18, 32'(PPR_RST));
    check(32'(interp), 32'h800);
    wr_reg(MOTOR_CFG_OFS, 32'h0711);
    wr_reg(MOTOR_CFG_OFS, 32'h0c11);
    @(negedge clk);
    check(32'(interp), 32'h80);
    a0 = 16'($random(seed));
    @(posedge clk);
    angle <= a0; run <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b0; angle <= ~a0;
    repeat (3) @(posedge clk);
    run <= 1'b1;
    rd_reg(LEARN_BASE_OFS + 8'h20, 32'(a0));
    run <= 1'b0;
    wr_reg(TUNE_STAT_OFS, 32'h5);
    rd_reg(TUNE_STAT_OFS, 32'h0);
    wr_reg(MOTOR_CFG_OFS, 32'h0710);
    for (int c = 0; c < 16; c++) begin
      // New learned base only for codes 0 to 7
      if (c <= int'(CODE_MAX)) lbase <= 16'($random(seed));
      run_tune(4'(c), 1'b0);
    end
    rd_reg(LEARN_BASE_OFS, 32'(lbase));
    rd_reg(LEARN_BASE_OFS + 8'h18, 32'(lbase + 16'h6));
    mv = 32'($random(seed)) & 32'hffff;
    wr_reg(LEARN_BASE_OFS, mv);
    wr_reg(LEARN_BASE_OFS + 8'h18, ~mv);
    rd_reg(LEARN_BASE_OFS, mv);
    rd_reg(LEARN_BASE_OFS + 8'h18, 32'(lbase + 16'h6));
    wr_reg(MOTOR_CFG_OFS, 32'h0711);
    lbase <= 16'($random(seed));
    run_tune(4'h3, 1'b0);
    rd_reg(LEARN_BASE_OFS, mv);
    keep = lbase + 16'h6;
    rd_reg(LEARN_BASE_OFS + 8'h18, 32'(keep));
    freq_fail <= 1'b1;
    lbase <= ~lbase;
    run_tune(4'h4, 1'b1);
    freq_fail <= 1'b0;
    rd_reg(LEARN_BASE_OFS + 8'h18, 32'(keep));
    do_reset();
    quad(1'b1);
    d1 = edir;
    quad(1'b0);
    check(32'(edir), 32'(!d1));
    wr_reg(MOTOR_CFG_OFS, 32'h0b00);
    quad(1'b1);
    check(32'(edir), 32'(!d1));
    for (int t = 0; t < 2; t++) begin
      do_reset();
      freq <= 16'd500;
      wr_reg(PROT_MODE_OFS, 32'(t) << 4);
      wr_reg(OVL_TIME_OFS, 32'h4);
      cur <= 16'd15000;
      wait_fault(0, n);
      check(32'(n < 80), 32'h1);
      check(32'(n <= 2 * TK + 6), 32'(t == 0));
    end
    for (int m = 1; m < 3; m++) begin
      do_reset();
      wr_reg(PROT_MODE_OFS, 32'(m));
      cur <= 16'd20000; therm <= (m == 1) ? THR_RST : 16'hffff;
      repeat (60) @(posedge clk);
      check({30'h0, f_ovl, f_oh}, 32'h0);
    end
    do_reset();
    wr_reg(PROT_MODE_OFS, 32'h1);
    cur <= 16'd20000; therm <= THR_RST + 16'h1;
    @(posedge clk);
    @(negedge clk);
    check(32'(f_oh), 32'h1);
    check(32'(f_ovl), 32'h0);
    do_reset();
    therm <= 16'h0;
    wr_reg(PROT_MODE_OFS, 32'h1);
    wr_reg(LO_LVL_OFS, 32'd11000);
    wr_reg(LO_TIME_OFS, 32'h2);
    wr_reg(HI_TIME_OFS, 32'h1);
    freq <= 16'd500; cur <= 16'd11001;
    wait_fault(1, n);
    check(32'(n > 2 * TK - 2 && n <= 4 * TK + 4), 32'h1);
    check(32'(f_hi), 32'h0);
    @(posedge clk);
    freq <= 16'd5000; cur <= 16'd12001;
    wait_fault(2, n);
    check(32'(n <= 2 * TK + 4), 32'h1);
    rd_reg(FAULT_OFS, 32'hc);
    cur <= 16'h0;
    repeat (3) @(posedge clk);
    wr_reg(FAULT_OFS, 32'hc);
    rd_reg(FAULT_OFS, 32'h0);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : motor_tune_and_protect_test
